// file: hdl/cag_regs.vh
// constants for the operand and jump address generator
// assumes inclusion by cag_core.v and the checker and bench files, not by cag_ram.v
`ifndef CAG_REGS_VH
`define CAG_REGS_VH

// data memory map, 16-bit data addresses
`define CAG_LORAM_LO     16'h0000
`define CAG_LORAM_HI     16'h006f
`define CAG_ONES_LO      16'h0070
`define CAG_ONES_HI      16'h007f
`define CAG_REGRAM_LO    16'h00f0
`define CAG_REGRAM_HI    16'h00fb
`define CAG_HIRAM_LO     16'h0100
`define CAG_HIRAM_HI     16'h013f
`define CAG_ADDR_PSW     16'h00ef
`define CAG_ADDR_XPTR    16'h00fc
`define CAG_ADDR_SP      16'h00fd
`define CAG_ADDR_BPTR    16'h00fe
`define CAG_ADDR_SEG     16'h00ff
`define CAG_SEG0_TOP     16'h00ff
`define CAG_SEGMENTED    8'h80
`define CAG_ALL_ONES     8'hff
`define CAG_UNDEF_DATA   8'h00

// ram index bases: register block, upper block; lower block starts at index 0
`define CAG_IDX_REGRAM   8'h70
`define CAG_IDX_HIRAM    8'h7c

// decoded regions
`define CAG_RG_NONE      4'h0
`define CAG_RG_RAM       4'h1
`define CAG_RG_ONES      4'h2
`define CAG_RG_PSW       4'h3
`define CAG_RG_XPTR      4'h4
`define CAG_RG_SP        4'h5
`define CAG_RG_BPTR      4'h6
`define CAG_RG_SEG       4'h7
`define CAG_RG_EXT       4'h8

// status word bit positions
`define CAG_PSW_GIE      0
`define CAG_PSW_CARRY    6
`define CAG_PSW_HC       7

// reset values
`define CAG_RST_BYTE     8'h00
`define CAG_RST_SP       8'h6f
`define CAG_RST_PC       15'h0000

// operation codes on op_code
`define CAG_OP_NOP       4'h0
`define CAG_OP_LD_IND    4'h1
`define CAG_OP_X_IND     4'h2
`define CAG_OP_LD_DIR    4'h3
`define CAG_OP_X_DIR     4'h4
`define CAG_OP_ST_DIR    4'h5
`define CAG_OP_LD_IMM    4'h6
`define CAG_OP_LD_BIMM   4'h7
`define CAG_OP_TBL_LOAD  4'h8
`define CAG_OP_TBL_JUMP  4'h9
`define CAG_OP_REL_JUMP  4'ha
`define CAG_OP_SEG_JUMP  4'hb
`define CAG_OP_SEG_CALL  4'hc
`define CAG_OP_LONG_JUMP 4'hd
`define CAG_OP_LONG_CALL 4'he
`define CAG_OP_VECTOR    4'hf

// pointer update codes on op_upd
`define CAG_UPD_NONE     2'h0
`define CAG_UPD_INC      2'h1
`define CAG_UPD_DEC      2'h2

`endif

// file: hdl/cag_ram.v
// on-chip data ram, one port, registered read data
// assumes a single clock and an index already decoded by the caller
`timescale 1ns/1ps
module cag_ram #(
  parameter DEPTH = 192,
  parameter AW    = 8
) (
  input  wire          clk,    // core clock
  input  wire          rd,     // read strobe
  input  wire          we,     // write strobe
  input  wire [AW-1:0] addr,   // byte index
  input  wire [7:0]    wdata,  // write byte
  output reg  [7:0]    rdata   // read byte, one cycle after rd
);

  reg [7:0] mem [0:DEPTH-1];

  // write and read share the index; read returns old contents
  always @(posedge clk)
  begin
    if (we)
      mem[addr] <= wdata;
    if (rd)
      rdata <= mem[addr];
  end

endmodule // cag_ram

// file: hdl/cag_core.v
// operand and jump address generation for an 8-bit core
// assumes one op at a time from a decoder, program memory with one cycle
// read latency, and peripherals answering ext_rd one cycle later
//
// Overview of operation
// RQ1 - reads of 0070-007F return all ones
// RQ2 - unimplemented segments read undefined data
// RQ3 - indirect operand addressed by either pointer
// RQ4 - pointer auto-update after the memory access
// RQ5 - direct mode uses 8-bit address field
// RQ6 - immediate mode takes 8-bit stream byte
// RQ7 - first pointer load takes 4-bit immediate
// RQ8 - table load addresses program memory by accumulator
// RQ9 - short jump adds signed -31..+32 field
// RQ10 - relative jump of one acts as nop
// RQ11 - relative target carries across 15 bits
// RQ12 - segment jump replaces low 12 bits
// RQ13 - long jump loads all 15 bits
// RQ14 - table jump loads fetched byte low
// RQ15 - vector loads two adjacent bytes into counter
// RQ16 - 15-bit counter, 7 upper, 8 lower
// RQ17 - accumulator, pointers, stack pointer 8 bits
// RQ18 - status word holds carry, half carry, enable
// RQ19 - register window F0-FF holds pointers
// RQ20 - F0-FB ram, FC-FF pointer registers
// RQ21 - second ram block 0100-013F
// RQ22 - lower ram 0000-006F
// RQ23 - opcode selects increment or decrement
`timescale 1ns/1ps
`include "cag_regs.vh"
module cag_core #(
  parameter RAM_DEPTH = 192,
  parameter RAM_AW    = 8
) (
  input  wire        mclk,              // core clock, 200 MHz
  input  wire        srst,              // synchronous reset, high
  input  wire        op_valid,          // op offered
  input  wire [3:0]  op_code,           // operation
  input  wire [1:0]  op_len,            // op length in bytes
  input  wire [14:0] op_field,          // address or jump field
  input  wire [7:0]  op_imm,            // immediate byte
  input  wire        op_psel,           // 0 first, 1 second pointer
  input  wire [1:0]  op_upd,            // pointer auto-update
  output wire        op_ready,          // op taken when valid
  output reg  [14:0] pm_addr,           // program memory address
  output wire        pm_rd,             // program memory read
  input  wire [7:0]  pm_rdata,          // program byte, next cycle
  output reg  [15:0] ext_addr,          // peripheral address
  output wire        ext_rd,            // peripheral read
  output wire        ext_wr,            // peripheral write
  output reg  [7:0]  ext_wdata,         // peripheral write byte
  input  wire [7:0]  ext_rdata,         // peripheral byte, next cycle
  output reg  [7:0]  acc,               // accumulator
  output reg  [14:0] pc,                // program counter
  output reg  [7:0]  first_index,       // first index pointer
  output reg  [7:0]  second_index,      // second index pointer
  output reg  [7:0]  stack_top,         // stack pointer
  output reg  [7:0]  data_segment,      // segment select
  output reg  [7:0]  status_word,       // status word
  output wire        carry_flag,        // status carry
  output wire        half_carry_flag,   // status half carry
  output wire        global_irq_enable  // status interrupt enable
);
  localparam ST_IDLE = 3'h0;
  localparam ST_MADR = 3'h1;
  localparam ST_MRD  = 3'h2;
  localparam ST_PMA  = 3'h3;
  localparam ST_PMD  = 3'h4;
  localparam ST_PUSH = 3'h5;
  //////////////////////////////////////////////////////////////////////
  // decode functions, shared by operand, stack and write paths

  // region of a 16-bit data address
  function [3:0] region;
    input [15:0] a;
    begin
      // RQ22 lower ram block
      if (a <= `CAG_LORAM_HI)
        region = `CAG_RG_RAM;
      // RQ1 unused block reads as ones
      else if (a >= `CAG_ONES_LO && a <= `CAG_ONES_HI)
        region = `CAG_RG_ONES;
      // RQ20 general register ram
      else if (a >= `CAG_REGRAM_LO && a <= `CAG_REGRAM_HI)
        region = `CAG_RG_RAM;
      // RQ19 pointer registers fc-ff map onto consecutive region codes
      else if (a >= `CAG_ADDR_XPTR && a <= `CAG_ADDR_SEG)
        region = `CAG_RG_XPTR + {2'b00, a[1:0]};
      else if (a == `CAG_ADDR_PSW)
        region = `CAG_RG_PSW;
      // RQ21 second ram block
      else if (a >= `CAG_HIRAM_LO && a <= `CAG_HIRAM_HI)
        region = `CAG_RG_RAM;
      else if (a <= `CAG_SEG0_TOP)
        region = `CAG_RG_EXT;
      // RQ2 other segments: nothing answers
      else
        region = `CAG_RG_NONE;
    end
  endfunction
  // ram index of an address known to be in a ram region; sum kept wide, then cut
  function [7:0] ram_index;
    input [15:0] a;
    reg   [15:0] t;
    begin
      if (a <= `CAG_LORAM_HI)
        t = a;
      else if (a <= `CAG_REGRAM_HI)
        t = a - `CAG_REGRAM_LO + {8'h00, `CAG_IDX_REGRAM};
      else
        t = a - `CAG_HIRAM_LO + {8'h00, `CAG_IDX_HIRAM};
      ram_index = t[7:0];
    end
  endfunction
  // 8-bit operand address to 16 bits; low half follows the segment
  function [15:0] seg_addr;
    input [7:0] a8;
    input [7:0] sg;
    seg_addr = (a8 < `CAG_SEGMENTED) ? {sg, a8} : {8'h00, a8};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // state
  reg [2:0]  state_r;
  reg [3:0]  op_r;        // op in flight
  reg        psel_r;
  reg [1:0]  upd_r;
  reg [15:0] maddr_r;     // data address in flight
  reg [3:0]  rgn_r;       // its region
  reg        mwr_r;       // access writes in address phase
  reg [14:0] target_r;    // call target or fetched vector high byte
  reg        vis_lo_r;    // vector low byte pending
  reg [7:0]  mrdata;
  wire [7:0]  ram_q;
  wire [7:0]  ptr_sel  = op_psel ? second_index : first_index;
  wire [15:0] ind_addr = seg_addr(ptr_sel, data_segment);
  wire [15:0] dir_addr = seg_addr(op_field[7:0], data_segment);
  // RQ3 pointer address for indirect ops, else the direct field
  wire        ind_op   = (op_code == `CAG_OP_LD_IND) || (op_code == `CAG_OP_X_IND);
  wire [15:0] op_addr  = ind_op ? ind_addr : dir_addr;
  wire [14:0] seg_tgt  = {pc[14:12], op_field[11:0]};
  // RQ23 auto-update direction from the op; decrement adds all ones
  wire        ptr_upd  = (op_r == `CAG_OP_LD_IND || op_r == `CAG_OP_X_IND) &&
                         (upd_r == `CAG_UPD_INC || upd_r == `CAG_UPD_DEC);
  wire [7:0]  ptr_step = (upd_r == `CAG_UPD_INC) ? 8'h01 : `CAG_ALL_ONES;
  wire        take     = op_valid && (state_r == ST_IDLE);
  wire [14:0] next_pc  = pc + {13'h0000, op_len};
  // RQ9 field -32..31 plus one gives -31..+32
  wire [14:0] rel_disp = {{9{op_field[5]}}, op_field[5:0]} + 15'h0001;
  // RQ11 full-width add, no page limit
  wire [14:0] rel_pc   = pc + rel_disp;
  // exchange writes the old accumulator back in the data phase
  wire        xwr      = (state_r == ST_MRD) &&
                         (op_r == `CAG_OP_X_IND || op_r == `CAG_OP_X_DIR);
  wire        awr      = (state_r == ST_MADR) && mwr_r;
  wire        dwr      = xwr || awr;
  wire        push_wr  = (state_r == ST_IDLE && take &&
                         (op_code == `CAG_OP_SEG_CALL || op_code == `CAG_OP_LONG_CALL))
                         || state_r == ST_PUSH;
  wire [15:0] push_adr = (state_r == ST_PUSH) ? {8'h00, stack_top - 8'h01}
                                              : {8'h00, stack_top};
  wire [7:0]  push_dat = (state_r == ST_PUSH) ? {1'b0, pc[14:8]} : next_pc[7:0];
  wire [15:0] ram_adr  = push_wr ? push_adr : maddr_r;
  wire        ram_we   = (push_wr && region(push_adr) == `CAG_RG_RAM) ||
                         (dwr && rgn_r == `CAG_RG_RAM);

  assign op_ready          = (state_r == ST_IDLE);
  assign pm_rd             = (state_r == ST_PMA);
  assign ext_rd            = (state_r == ST_MADR) && !mwr_r && (rgn_r == `CAG_RG_EXT);
  assign ext_wr            = dwr && (rgn_r == `CAG_RG_EXT);
  // RQ18 single-bit flags of the status word
  assign carry_flag        = status_word[`CAG_PSW_CARRY];
  assign half_carry_flag   = status_word[`CAG_PSW_HC];
  assign global_irq_enable = status_word[`CAG_PSW_GIE];

  // stack pushes reuse the ram port; the op stream is stalled meanwhile
  cag_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW)
  ) u_ram (
    .clk   (mclk),
    .rd    (state_r == ST_MADR && !mwr_r),
    .we    (ram_we),
    .addr  (ram_index(ram_adr)),
    .wdata (push_wr ? push_dat : ext_wdata),
    .rdata (ram_q)
  );

  //////////////////////////////////////////////////////////////////////
  // read data select for the data phase
  always @*
  begin
    case (rgn_r)
      `CAG_RG_RAM:  mrdata = ram_q;
      // RQ1 fixed ones
      `CAG_RG_ONES: mrdata = `CAG_ALL_ONES;
      `CAG_RG_PSW:  mrdata = status_word;
      `CAG_RG_XPTR: mrdata = second_index;
      `CAG_RG_SP:   mrdata = stack_top;
      `CAG_RG_BPTR: mrdata = first_index;
      `CAG_RG_SEG:  mrdata = data_segment;
      `CAG_RG_EXT:  mrdata = ext_rdata;
      // RQ2 undefined data, tied to a constant
      default:      mrdata = `CAG_UNDEF_DATA;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer and architectural registers
  // RQ16 RQ17 widths fixed by the declarations above
  always @(posedge mclk)
  begin
    if (srst)
    begin
      // op context regs are only read behind state_r, so they need no reset
      state_r      <= ST_IDLE;
      rgn_r        <= `CAG_RG_NONE;
      pm_addr      <= `CAG_RST_PC;
      ext_addr     <= 16'h0000;
      ext_wdata    <= `CAG_RST_BYTE;
      acc          <= `CAG_RST_BYTE;
      pc           <= `CAG_RST_PC;
      first_index  <= `CAG_RST_BYTE;
      second_index <= `CAG_RST_BYTE;
      stack_top    <= `CAG_RST_SP;
      data_segment <= `CAG_RST_BYTE;
      status_word  <= `CAG_RST_BYTE;
    end
    else
    begin
      // memory-mapped register writes from store or exchange
      if (dwr)
      begin
        case (rgn_r)
          `CAG_RG_PSW:  status_word  <= ext_wdata;
          `CAG_RG_XPTR: second_index <= ext_wdata;
          `CAG_RG_SP:   stack_top    <= ext_wdata;
          `CAG_RG_BPTR: first_index  <= ext_wdata;
          `CAG_RG_SEG:  data_segment <= ext_wdata;
          default:      ;
        endcase
      end
      case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            op_r      <= op_code;
            psel_r    <= op_psel;
            upd_r     <= op_upd;
            mwr_r     <= (op_code == `CAG_OP_ST_DIR);
            ext_wdata <= acc;
            case (op_code)
              // RQ3 RQ5 operand at pointer or direct 8-bit address
              `CAG_OP_LD_IND, `CAG_OP_X_IND, `CAG_OP_LD_DIR, `CAG_OP_X_DIR, `CAG_OP_ST_DIR:
              begin
                maddr_r  <= op_addr;
                ext_addr <= op_addr;
                rgn_r    <= region(op_addr);
                pc       <= next_pc;
                state_r  <= ST_MADR;
              end
              // RQ6 operand from the stream
              `CAG_OP_LD_IMM:
              begin
                acc <= op_imm;
                pc  <= next_pc;
              end
              // RQ7 short immediate into first pointer
              `CAG_OP_LD_BIMM:
              begin
                first_index <= {4'h0, op_imm[3:0]};
                pc          <= next_pc;
              end
              // RQ8 RQ14 accumulator indexes the current page
              `CAG_OP_TBL_LOAD, `CAG_OP_TBL_JUMP:
              begin
                pm_addr <= {pc[14:8], acc};
                state_r <= ST_PMA;
              end
              // RQ10 field of zero means plus one, same as a nop
              `CAG_OP_REL_JUMP:
                pc <= (op_field[5:0] == 6'h00) ? next_pc : rel_pc;
              // RQ12 keep upper bits and the 4k segment
              `CAG_OP_SEG_JUMP:
                pc <= seg_tgt;
              // RQ13 whole counter from the field
              `CAG_OP_LONG_JUMP:
                pc <= op_field;
              // calls latch the target; first push now, second with the target load
              `CAG_OP_SEG_CALL, `CAG_OP_LONG_CALL:
              begin
                target_r <= (op_code == `CAG_OP_SEG_CALL) ? seg_tgt : op_field;
                state_r  <= ST_PUSH;
              end
              // RQ15 vector slot high byte first
              `CAG_OP_VECTOR:
              begin
                pm_addr  <= op_field;
                vis_lo_r <= 1'b0;
                state_r  <= ST_PMA;
              end
              default:
                pc <= next_pc;
            endcase
          end
        end
        ST_MADR:
          state_r <= mwr_r ? ST_IDLE : ST_MRD;
        ST_MRD:
        begin
          acc     <= mrdata;
          state_r <= ST_IDLE;
          // RQ4 update after the access; wins over a write to itself
          if (ptr_upd && psel_r)
            second_index <= second_index + ptr_step;
          else if (ptr_upd)
            first_index  <= first_index + ptr_step;
        end
        ST_PMA:
          state_r <= ST_PMD;
        ST_PMD:
        begin
          state_r <= ST_IDLE;
          if (op_r == `CAG_OP_TBL_LOAD)
          begin
            acc <= pm_rdata;
            pc  <= next_pc;
          end
          // RQ14 fetched byte becomes the low counter byte
          else if (op_r == `CAG_OP_TBL_JUMP)
            pc <= {pc[14:8], pm_rdata};
          // RQ15 adjacent low byte, then the whole counter
          else if (!vis_lo_r)
          begin
            target_r[14:8] <= pm_rdata[6:0];
            pm_addr        <= pm_addr + 15'h0001;
            vis_lo_r       <= 1'b1;
            state_r        <= ST_PMA;
          end
          else
            pc <= {target_r[14:8], pm_rdata};
        end
        // second push byte and the call target load, in the same cycle
        ST_PUSH:
        begin
          stack_top <= stack_top - 8'h02;
          pc        <= target_r;
          state_r   <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // cag_core

// file: tb/cag_core_chk.sv
// port assertions for the operand and jump address generator
// assumes a bind onto cag_core, one clock, srst synchronous and high
`timescale 1ns/1ps
`include "cag_regs.vh"
module cag_core_chk (
  input wire        mclk,              // core clock
  input wire        srst,              // sync reset
  input wire        op_valid,          // op offered
  input wire [3:0]  op_code,           // operation
  input wire [14:0] op_field,          // jump or address field
  input wire [7:0]  op_imm,            // immediate byte
  input wire        op_psel,           // pointer select
  input wire [1:0]  op_upd,            // pointer update
  input wire        op_ready,          // op taken
  input wire [14:0] pm_addr,           // program address
  input wire        pm_rd,             // program read
  input wire [15:0] ext_addr,          // peripheral address
  input wire        ext_rd,            // peripheral read
  input wire        ext_wr,            // peripheral write
  input wire [7:0]  acc,               // accumulator
  input wire [14:0] pc,                // program counter
  input wire [7:0]  first_index,       // first pointer
  input wire [7:0]  stack_top,         // stack pointer
  input wire        carry_flag,        // carry
  input wire        half_carry_flag,   // half carry
  input wire        global_irq_enable  // interrupt enable
);
  ////////////////////////////////////////////////////////////////
  // targets worked out from the state seen at the take edge
  wire        take    = op_valid && op_ready;
  wire [14:0] rel_tgt = pc + {{9{op_field[5]}}, op_field[5:0]} + 15'h0001;
  wire [14:0] seg_tgt = {pc[14:12], op_field[11:0]};
  wire [14:0] tbl_adr = {pc[14:8], acc};
  wire [2:0]  flag_src = {acc[7], acc[6], acc[0]};
  wire        ptr_inc = take && op_code == `CAG_OP_LD_IND && !op_psel && op_upd == `CAG_UPD_INC;
  reg  [7:0]  ptr_q;

  // pointer captured at take, since the update lands a few cycles later
  always @(posedge mclk)
  begin
    if (take)
      ptr_q <= first_index;
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////
  // counter cleared by reset
  reset_vals_a: assert property (disable iff (1'b0)
    srst |=> pc == `CAG_RST_PC && stack_top == `CAG_RST_SP && op_ready && !pm_rd)
    else $error("reset state wrong");
  flag_bits_a: assert property (
    take && op_code == `CAG_OP_ST_DIR && op_field[7:0] == 8'hef |=> ##1
    {half_carry_flag, carry_flag, global_irq_enable} == $past(flag_src, 2))
    else $error("status flags not loaded");
  imm_load_a: assert property (
    take && op_code == `CAG_OP_LD_IMM |=> acc == $past(op_imm) && op_ready)
    else $error("immediate load wrong");
  short_imm_a: assert property (
    take && op_code == `CAG_OP_LD_BIMM |=> first_index == ($past(op_imm) & 8'h0f))
    else $error("short immediate wrong");
  long_jump_a: assert property (
    take && op_code == `CAG_OP_LONG_JUMP |=> pc == $past(op_field))
    else $error("long jump target wrong");
  seg_jump_a: assert property (
    take && op_code == `CAG_OP_SEG_JUMP |=> pc == $past(seg_tgt))
    else $error("segment jump target wrong");
  rel_jump_a: assert property (
    take && op_code == `CAG_OP_REL_JUMP && op_field[5:0] != 6'h00 |=> pc == $past(rel_tgt))
    else $error("relative jump target wrong");
  table_addr_a: assert property (
    take && op_code == `CAG_OP_TBL_LOAD |=> pm_rd && pm_addr == $past(tbl_adr))
    else $error("table fetch address wrong");
  // local places never reach the port
  periph_range_a: assert property (
    ext_rd || ext_wr |-> ext_addr[15:7] == 9'h001 && ext_addr[7:4] != 4'hf
    && ext_addr[7:0] != 8'hef)
    else $error("local address sent to peripheral port");
  ptr_post_a: assert property (
    ptr_inc |=> first_index == ptr_q ##[1:3] first_index == ptr_q + 8'h01)
    else $error("pointer update out of order");

  vector_c: cover property (take && op_code == `CAG_OP_VECTOR);
  call_c:   cover property (take && op_code == `CAG_OP_LONG_CALL);
  xdec_c:   cover property (take && op_code == `CAG_OP_X_IND && op_upd == `CAG_UPD_DEC);
endmodule // cag_core_chk

bind cag_core cag_core_chk u_chk (.*);

// file: tb/cag_far_model.sv
// program memory and peripheral stand-in facing the generator
// assumes reads strobed on mclk with the byte due one cycle later
`timescale 1ns/1ps
module cag_far_model (
  input  wire        mclk,      // core clock
  input  wire [14:0] pm_addr,   // program address
  input  wire        pm_rd,     // program read
  output reg  [7:0]  pm_rdata,  // program byte
  input  wire [15:0] ext_addr,  // peripheral address
  input  wire        ext_rd,    // peripheral read
  input  wire        ext_wr,    // peripheral write
  input  wire [7:0]  ext_wdata, // peripheral write byte
  output reg  [7:0]  ext_rdata, // peripheral byte
  output reg  [7:0]  wr_seen    // last byte written
);
  initial
  begin
    pm_rdata  = 8'h00;
    ext_rdata = 8'h00;
    wr_seen   = 8'h00;
  end

  // bytes valid only the cycle after a strobe; inverted otherwise so a late sample shows
  always @(posedge mclk)
  begin
    pm_rdata  <= pm_rd ? (pm_addr[7:0] ^ {1'b0, pm_addr[14:8]}) : ~pm_rdata;
    ext_rdata <= ext_rd ? (ext_addr[7:0] ^ 8'h5a) : ~ext_rdata;
    if (ext_wr)
      wr_seen <= ext_wdata;
  end
endmodule // cag_far_model

// file: tb/cag_core_tb.sv
// self-checking bench for the operand and jump address generator
// assumes cag_core, the far-side model and the bound checker
`timescale 1ns/1ps
`include "cag_regs.vh"
module cag_core_tb;
  reg         mclk = 1'b0;         // core clock
  reg         srst = 1'b1;         // sync reset
  reg         op_valid = 1'b0;     // op offered
  reg         op_psel = 1'b0;      // pointer select
  reg  [3:0]  op_code = 4'h0;      // operation
  reg  [1:0]  op_len = 2'h0;       // op length
  reg  [1:0]  op_upd = 2'h0;       // pointer update
  reg  [14:0] op_field = 15'h0000; // address or jump field
  reg  [7:0]  op_imm = 8'h00;      // immediate byte
  wire        op_ready, pm_rd, ext_rd, ext_wr, carry_flag, half_carry_flag, global_irq_enable;
  wire [14:0] pm_addr, pc;
  wire [15:0] ext_addr;
  wire [7:0]  pm_rdata, ext_wdata, ext_rdata, acc, first_index, second_index;
  wire [7:0]  stack_top, data_segment, status_word, wr_seen;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  typedef struct packed {logic [3:0] c; logic [1:0] l; logic [14:0] v; logic [2:0] pu;
    logic [7:0] ea; logic [14:0] ep;} cag_row_t;
  cag_row_t   rows[$];

  // every port has a bench signal of the same name
  cag_core uut (.*);
  cag_far_model far (.*);

  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      conclude;
    end
  end

  // value compare, four-state so an unknown never matches
  task cmp(input [14:0] got, input [14:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  // pu packs pointer select over update code
  task drive(input [3:0] c, input [1:0] l, input [14:0] v, input [2:0] pu);
  begin
    {op_code, op_len, op_field, op_imm, op_psel, op_upd} = {c, l, v, v[7:0], pu};
    op_valid = 1'b1;
  end
  endtask

  // one op, then a bounded wait for the generator to go idle
  task op(input [3:0] c, input [1:0] l, input [14:0] v, input [2:0] pu);
    integer n;
  begin
    drive(c, l, v, pu);
    @(negedge mclk);
    op_valid = 1'b0;
    n = 0;
    @(negedge mclk);
    while (op_ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n = n + 1;
    end
  end
  endtask

  task add(input [3:0] c, input [1:0] l, input [14:0] v, input [2:0] pu, input [7:0] ea,
    input [14:0] ep);
    rows.push_back({c, l, v, pu, ea, ep});
  endtask

  task conclude;
  begin
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    add(`CAG_OP_LD_IMM, 2, 15'h3c, 0, 8'h3c, 15'h0002);
    add(`CAG_OP_LD_BIMM, 1, 15'ha5, 0, 8'h3c, 15'h0003);
    add(`CAG_OP_LD_DIR, 2, 15'h75, 0, 8'hff, 15'h0005);
    add(`CAG_OP_LD_DIR, 2, 15'hc0, 0, 8'h9a, 15'h0007);
    add(`CAG_OP_LD_IMM, 2, 15'h77, 0, 8'h77, 15'h0009);
    add(`CAG_OP_ST_DIR, 2, 15'h05, 0, 8'h77, 15'h000b);
    add(`CAG_OP_LD_IMM, 2, 15'h21, 0, 8'h21, 15'h000d);
    add(`CAG_OP_ST_DIR, 2, 15'h06, 0, 8'h21, 15'h000f);
    add(`CAG_OP_LD_IND, 1, 15'h00, 3'h1, 8'h77, 15'h0010);
    add(`CAG_OP_X_IND, 1, 15'h00, 3'h2, 8'h21, 15'h0011);
    add(`CAG_OP_LD_DIR, 2, 15'h06, 0, 8'h77, 15'h0013);
    add(`CAG_OP_LD_IMM, 2, 15'h06, 0, 8'h06, 15'h0015);
    add(`CAG_OP_ST_DIR, 2, 15'hfc, 0, 8'h06, 15'h0017);
    add(`CAG_OP_LD_IND, 1, 15'h00, 3'h4, 8'h77, 15'h0018);
    add(`CAG_OP_REL_JUMP, 1, 15'h1f, 0, 8'h77, 15'h0038);
    add(`CAG_OP_REL_JUMP, 1, 15'h20, 0, 8'h77, 15'h0019);
    add(`CAG_OP_REL_JUMP, 1, 15'h00, 0, 8'h77, 15'h001a);
    add(`CAG_OP_LONG_JUMP, 3, 15'h10f0, 0, 8'h77, 15'h10f0);
    add(`CAG_OP_REL_JUMP, 1, 15'h1f, 0, 8'h77, 15'h1110);
    add(`CAG_OP_SEG_JUMP, 2, 15'habc, 0, 8'h77, 15'h1abc);
    add(`CAG_OP_TBL_LOAD, 1, 15'h00, 0, 8'h6d, 15'h1abd);
    add(`CAG_OP_TBL_JUMP, 1, 15'h00, 0, 8'h6d, 15'h1a77);
    add(`CAG_OP_VECTOR, 1, 15'h31c0, 0, 8'h6d, 15'h71f0);
    add(`CAG_OP_SEG_CALL, 2, 15'h345, 0, 8'h6d, 15'h7345);
    add(`CAG_OP_LONG_CALL, 3, 15'h0123, 0, 8'h6d, 15'h0123);
    add(`CAG_OP_LD_DIR, 2, 15'h6f, 0, 8'hf2, 15'h0125);
    add(`CAG_OP_LD_DIR, 2, 15'h6e, 0, 8'h71, 15'h0127);
    add(`CAG_OP_LD_IMM, 2, 15'h01, 0, 8'h01, 15'h0129);
    add(`CAG_OP_ST_DIR, 2, 15'hff, 0, 8'h01, 15'h012b);
    add(`CAG_OP_ST_DIR, 2, 15'h20, 0, 8'h01, 15'h012d);
    add(`CAG_OP_LD_IMM, 2, 15'h00, 0, 8'h00, 15'h012f);
    add(`CAG_OP_X_DIR, 2, 15'h20, 0, 8'h01, 15'h0131);
    add(`CAG_OP_LD_DIR, 2, 15'h20, 0, 8'h00, 15'h0133);
    foreach (rows[k])
    begin
      op(rows[k].c, rows[k].l, rows[k].v, rows[k].pu);
      cmp({7'h00, acc}, {7'h00, rows[k].ea});
      cmp(pc, rows[k].ep);
    end
    $display("row tests done");
    cmp({7'h00, first_index}, 15'h0005);
    cmp({7'h00, second_index}, 15'h0006);
    cmp({7'h00, stack_top}, 15'h006b);
    cmp({7'h00, data_segment}, 15'h0001);
    $display("pointer and stack state checked");
    op(`CAG_OP_LD_IMM, 2, 15'h81, 0);
    op(`CAG_OP_ST_DIR, 2, 15'hc1, 0);
    op(`CAG_OP_ST_DIR, 2, 15'hef, 0);
    cmp({7'h00, wr_seen}, 15'h0081);
    cmp({half_carry_flag, carry_flag, global_irq_enable}, 15'h0005);
    $display("status and peripheral write checked");
    // two ops on consecutive edges, valid held high between them
    drive(`CAG_OP_LD_BIMM, 1, 15'h2b, 0);
    @(negedge mclk);
    drive(`CAG_OP_LD_IMM, 2, 15'h22, 0);
    @(negedge mclk);
    op_valid = 1'b0;
    @(negedge mclk);
    cmp({7'h00, first_index}, 15'h000b);
    cmp({7'h00, acc}, 15'h0022);
    $display("back-to-back ops checked");
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    cmp(pc, 15'h0000);
    cmp({7'h00, stack_top}, 15'h006f);
    cmp({7'h00, acc}, 15'h0000);
    $display("mid-run reset checked");
    conclude;
  end
endmodule // cag_core_tb
